// ### design/fac_decode.sv
// array address decode: map hit and boot-block membership
// assumes 16-bit byte addresses, 32-kbyte array
`timescale 1ns/1ns
`default_nettype none
`include "fac_params.svh"
module fac_decode (
   input  wire logic [15:0] addr_i,
   input  wire logic        expanded_i,
   output logic             hit_o,
   output logic             boot_o
);
   // expanded modes keep the array out of the map altogether
   assign hit_o  = !expanded_i && (addr_i[15] == 1'(`FAC_BASE_SINGLE >> 15));
   assign boot_o = (addr_i[14:11] == `FAC_BOOT_TOP);
endmodule
`default_nettype wire

// ### design/fac_flash_ctrl.sv
// flash array control and interlocks: registers, array read path, program latches
// assumes a single-cycle array read port (data the cycle after the strobe)
// Notes on behaviour
// - array is 16-bit words; byte/aligned read one array cycle, misaligned two.
// - program one byte or aligned word at a time; erase only whole array.
// - top 2 kbytes of the array form the protected boot block.
// - single-chip after reset: array decoded at upper half of address space.
// - expanded modes: array off the map, never responds.
// - four byte registers from a fixed base, separate from array contents.
// - normal modes: lock bit takes one write after reset only.
// - lock set ignores module configuration writes; clear accepts them.
// - boot protect frozen while lock or program voltage enable set.
// - boot protect set blocks program and erase of boot block.
// - normal mode: test register writes ignored, reads zero.
// - stress enable drives stress circuit; select picks gate or drain.
// - status bit shows high voltage present during stress test.
// - supply low refuses capture arm set unless override test bit set.
// - threshold check steers control gate from supply pin, kills timeout.
// - spare row bit plus special mode selects reserved spare row.
// - multi-word program ignores two low address bits, writes two words.
// - stop-in-wait set halts module clock in wait mode.
// - read-only supply ok bit shows programming supply level.
// - voltage enable sets only with arm set and a write captured since.
// - while enable set only enable and stop-in-wait may change in control register.
// - reads ignored with enable; arm without wipe returns latched data.
// - arm set: next array write captured, later writes ignored.
`timescale 1ns/1ns
`default_nettype none
`include "fac_params.svh"
module fac_flash_ctrl (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // operating mode
   input  wire logic        special_mode_active_i,
   input  wire logic        expanded_mode_i,
   input  wire logic        wait_mode_i,
   // analogue sense pins
   input  wire logic        program_supply_pin_i,
   input  wire logic        stress_hv_pin_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // cpu array access
   input  wire logic [15:0] cpu_addr_i,
   input  wire logic [15:0] cpu_wdata_i,
   input  wire logic        cpu_byte_i,
   input  wire logic        cpu_rd_i,
   input  wire logic        cpu_wr_i,
   output logic      [15:0] cpu_rdata_o,
   output logic             cpu_rvalid_o,
   // array read port
   output logic      [13:0] array_word_o,
   output logic             array_rd_o,
   input  wire logic [15:0] array_rdata_i,
   // program and erase controls
   output logic      [15:0] prog_addr_o,
   output logic      [15:0] prog_data_o,
   output logic             prog_byte_o,
   output logic             prog_dual_o,
   output logic             prog_pulse_o,
   output logic             erase_main_o,
   output logic             erase_boot_o,
   // test controls and clock gate
   output logic             stress_en_o,
   output logic             stress_gate_o,
   output logic             low_voltage_en_o,
   output logic             threshold_check_o,
   output logic             sense_timeout_dis_o,
   output logic             spare_row_o,
   output logic             module_clk_en_o
);
   import fac_pkg::*;

   logic       supply_ok;
   logic       hv_seen;
   logic       cpu_hit, lat_boot;
   fac_sync #(.WIDTH(2)) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .pin_i   ({stress_hv_pin_i, program_supply_pin_i}),
      .level_o ({hv_seen, supply_ok})
   );

   fac_decode u_dec_cpu (
      .addr_i     (cpu_addr_i),
      .expanded_i (expanded_mode_i),
      .hit_o      (cpu_hit),
      .boot_o     ()
   );

   // register state
   logic       lock_reg, lock_next, lock_used_reg, lock_used_next;
   logic       boot_block_protect_reg, boot_block_protect_next;
   logic [7:0] test_reg, test_next;
   logic       swai_reg, swai_next;
   logic       wipe_reg, wipe_next;
   logic       arm_reg, arm_next;
   logic       enpv_reg, enpv_next;
   logic       capt_reg, capt_next;
   logic [15:0] lat_addr_reg, lat_addr_next;
   logic [15:0] lat_data_reg, lat_data_next;
   logic       lat_byte_reg, lat_byte_next;
   logic [7:0] rdata_reg, rdata_next;
   logic       special_mode_active;
   logic       wr_guard, wr_mcfg, wr_test, wr_ctl;
   logic       arm_ok;
   assign special_mode_active     = special_mode_active_i;
   assign wr_guard = reg_wr_i && (reg_addr_i == `FAC_OFS_GUARD);
   assign wr_mcfg  = reg_wr_i && (reg_addr_i == `FAC_OFS_MCFG);
   assign wr_test  = reg_wr_i && (reg_addr_i == `FAC_OFS_TEST);
   assign wr_ctl   = reg_wr_i && (reg_addr_i == `FAC_OFS_CTL);
   // arm may rise only with a good supply or the override
   assign arm_ok   = supply_ok || (special_mode_active && test_reg[`FAC_B_OVRD]);
   fac_decode u_dec_lat (
      .addr_i     (lat_addr_reg),
      .expanded_i (1'b0),
      .hit_o      (),
      .boot_o     (lat_boot)
   );

   always_comb begin
      lock_next      = lock_reg;
      lock_used_next = lock_used_reg;
      boot_block_protect_next     = boot_block_protect_reg;
      test_next      = test_reg;
      swai_next      = swai_reg;
      wipe_next      = wipe_reg;
      arm_next       = arm_reg;
      enpv_next      = enpv_reg;
      capt_next      = capt_reg;
      lat_addr_next  = lat_addr_reg;
      lat_data_next  = lat_data_reg;
      lat_byte_next  = lat_byte_reg;
      if (wr_guard && (special_mode_active || !lock_used_reg)) begin
         lock_next      = reg_wdata_i[`FAC_B_LOCK];
         lock_used_next = 1'b1;
      end
      if (wr_mcfg && !lock_reg && !enpv_reg) begin
         boot_block_protect_next = reg_wdata_i[`FAC_B_BOOT_BLOCK_PROTECT];
      end
      if (wr_test && special_mode_active) begin
         test_next = reg_wdata_i;
         test_next[`FAC_B_HVSEEN] = 1'b0;
      end
      if (wr_ctl) begin
         swai_next = reg_wdata_i[`FAC_B_SWAI];
         if (!enpv_reg) begin
            wipe_next = reg_wdata_i[`FAC_B_WIPE];
            if (!reg_wdata_i[`FAC_B_ARM]) begin
               arm_next  = 1'b0;
               capt_next = 1'b0;
            end else if (!arm_reg && arm_ok) begin
               arm_next  = 1'b1;
               capt_next = 1'b0;
            end
         end
         // enable follows the old arm, so arm and enable in one write leave enable clear
         enpv_next = reg_wdata_i[`FAC_B_ENPV] && arm_reg && capt_reg;
      end
      // one byte or aligned word; misaligned words never reach the latches
      if (cpu_wr_i && cpu_hit && arm_reg && !capt_reg && !enpv_reg
          && (cpu_byte_i || !cpu_addr_i[0])) begin
         capt_next     = 1'b1;
         lat_addr_next = cpu_addr_i;
         lat_data_next = cpu_wdata_i;
         lat_byte_next = cpu_byte_i;
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `FAC_OFS_GUARD: rdata_next[`FAC_B_LOCK]  = lock_reg;
            `FAC_OFS_MCFG:  rdata_next[`FAC_B_BOOT_BLOCK_PROTECT] = boot_block_protect_reg;
            `FAC_OFS_TEST: begin
               if (special_mode_active) begin
                  rdata_next = test_reg;
                  rdata_next[`FAC_B_HVSEEN] = hv_seen;
               end
            end
            `FAC_OFS_CTL: begin
               rdata_next[`FAC_B_SWAI]  = swai_reg;
               rdata_next[`FAC_B_SUPOK] = supply_ok;
               rdata_next[`FAC_B_WIPE]  = wipe_reg;
               rdata_next[`FAC_B_ARM]   = arm_reg;
               rdata_next[`FAC_B_ENPV]  = enpv_reg;
            end
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock_reg      <= 1'(`FAC_RST_GUARD >> `FAC_B_LOCK);
         lock_used_reg <= 1'b0;
         boot_block_protect_reg     <= 1'b0;
         test_reg      <= `FAC_RST_TEST;
         swai_reg      <= 1'b0;
         wipe_reg      <= 1'b0;
         arm_reg       <= 1'b0;
         enpv_reg      <= 1'b0;
         capt_reg      <= 1'b0;
         lat_addr_reg  <= 16'h0000;
         lat_data_reg  <= 16'h0000;
         lat_byte_reg  <= 1'b0;
         rdata_reg     <= 8'h00;
      end else begin
         lock_reg      <= lock_next;
         lock_used_reg <= lock_used_next;
         boot_block_protect_reg     <= boot_block_protect_next;
         test_reg      <= test_next;
         swai_reg      <= swai_next;
         wipe_reg      <= wipe_next;
         arm_reg       <= arm_next;
         enpv_reg      <= enpv_next;
         capt_reg      <= capt_next;
         lat_addr_reg  <= lat_addr_next;
         lat_data_reg  <= lat_data_next;
         lat_byte_reg  <= lat_byte_next;
         rdata_reg     <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // array read path
   fac_rd_state_t st_reg, st_next;
   logic [15:0] ra_reg, ra_next;
   logic        rbyte_reg, rbyte_next;
   logic        rmis_reg, rmis_next;
   logic [7:0]  rfirst_reg, rfirst_next;
   logic [15:0] out_reg, out_next;
   logic        vld_reg, vld_next;
   logic [13:0] aw_reg, aw_next;
   logic        ard_reg, ard_next;
   logic [7:0]  byte_sel;

   assign byte_sel = ra_reg[0] ? array_rdata_i[7:0] : array_rdata_i[15:8];
   always_comb begin
      st_next     = st_reg;
      ra_next     = ra_reg;
      rbyte_next  = rbyte_reg;
      rmis_next   = rmis_reg;
      rfirst_next = rfirst_reg;
      out_next    = out_reg;
      vld_next    = 1'b0;
      aw_next     = aw_reg;
      ard_next    = 1'b0;
      unique case (st_reg)
         FAC_IDLE: begin
            if (cpu_rd_i && cpu_hit) begin
               if (enpv_reg || (arm_reg && !wipe_reg)) begin
                  out_next = enpv_reg ? 16'h0000 : lat_data_reg;
                  vld_next = 1'b1;
               end else begin
                  ra_next    = cpu_addr_i;
                  rbyte_next = cpu_byte_i;
                  rmis_next  = !cpu_byte_i && cpu_addr_i[0];
                  aw_next    = cpu_addr_i[14:1];
                  ard_next   = 1'b1;
                  st_next    = FAC_RD1;
               end
            end
         end
         FAC_RD1: st_next = FAC_RD2;
         FAC_RD2: begin
            if (rmis_reg) begin
               rfirst_next = array_rdata_i[7:0];
               rmis_next   = 1'b0; // odd start kept: it selects the byte pairing
               aw_next     = aw_reg + 14'h0001;
               ard_next    = 1'b1;
               st_next     = FAC_RD1;
            end else begin
               if (rbyte_reg) begin
                  out_next = {8'h00, byte_sel};
               end else if (ra_reg[0]) begin
                  out_next = {rfirst_reg, array_rdata_i[15:8]};
               end else begin
                  out_next = array_rdata_i;
               end
               vld_next = 1'b1;
               st_next  = FAC_DONE;
            end
         end
         FAC_DONE: st_next = FAC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg     <= FAC_IDLE;
         ra_reg     <= 16'h0000;
         rbyte_reg  <= 1'b0;
         rmis_reg   <= 1'b0;
         rfirst_reg <= 8'h00;
         out_reg    <= 16'h0000;
         vld_reg    <= 1'b0;
         aw_reg     <= 14'h0000;
         ard_reg    <= 1'b0;
      end else begin
         st_reg     <= st_next;
         ra_reg     <= ra_next;
         rbyte_reg  <= rbyte_next;
         rmis_reg   <= rmis_next;
         rfirst_reg <= rfirst_next;
         out_reg    <= out_next;
         vld_reg    <= vld_next;
         aw_reg     <= aw_next;
         ard_reg    <= ard_next;
      end
   end
   assign cpu_rdata_o  = out_reg;
   assign cpu_rvalid_o = vld_reg;
   assign array_word_o = aw_reg;
   assign array_rd_o   = ard_reg;

   // program, erase and test outputs, all registered
   logic [15:0] paddr_reg, paddr_next;
   logic [11:0] ctl_next, ctl_reg;
   always_comb begin
      paddr_next = (special_mode_active && test_reg[`FAC_B_MWP]) ? {lat_addr_reg[15:2], 2'b00}
                                                 : lat_addr_reg;
      ctl_next[0]  = special_mode_active && test_reg[`FAC_B_MWP];
      ctl_next[1]  = enpv_reg && arm_reg && !wipe_reg
                     && !(boot_block_protect_reg && lat_boot);
      ctl_next[2]  = enpv_reg && arm_reg && wipe_reg;
      ctl_next[3]  = enpv_reg && arm_reg && wipe_reg && !boot_block_protect_reg;
      ctl_next[4]  = special_mode_active && test_reg[`FAC_B_STRESS];
      ctl_next[5]  = special_mode_active && test_reg[`FAC_B_GATE];
      ctl_next[6]  = special_mode_active && test_reg[`FAC_B_LOWV];
      ctl_next[7]  = special_mode_active && test_reg[`FAC_B_THRESHOLD_CHECK];
      ctl_next[8]  = special_mode_active && test_reg[`FAC_B_THRESHOLD_CHECK];
      ctl_next[9]  = special_mode_active && test_reg[`FAC_B_SPARE];
      ctl_next[10] = !(wait_mode_i && swai_reg);
      ctl_next[11] = lat_byte_reg;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         paddr_reg <= 16'h0000;
         ctl_reg   <= 12'h400;
      end else begin
         paddr_reg <= paddr_next;
         ctl_reg   <= ctl_next;
      end
   end
   assign prog_addr_o         = paddr_reg;
   assign prog_data_o         = lat_data_reg;
   assign prog_dual_o         = ctl_reg[0];
   assign prog_pulse_o        = ctl_reg[1];
   assign erase_main_o        = ctl_reg[2];
   assign erase_boot_o        = ctl_reg[3];
   assign stress_en_o         = ctl_reg[4];
   assign stress_gate_o       = ctl_reg[5];
   assign low_voltage_en_o    = ctl_reg[6];
   assign threshold_check_o   = ctl_reg[7];
   assign sense_timeout_dis_o = ctl_reg[8];
   assign spare_row_o         = ctl_reg[9];
   assign module_clk_en_o     = ctl_reg[10];
   assign prog_byte_o         = ctl_reg[11];
endmodule
`default_nettype wire

// ### design/fac_sync.sv
// pin synchroniser: four flops per bit, output follows once stages 2 and 3 agree
// assumes asynchronous pin levels, single clock clk_i
`timescale 1ns/1ns
`default_nettype none
module fac_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] level_o
);
   generate
      if (WIDTH < 1) begin : g_bad
         $error("fac_sync: WIDTH must be at least 1");
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
         // stage 1 feeds stage 2 only
         always_comb begin
            lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
         end
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               s1_reg  <= 1'b0;
               s2_reg  <= 1'b0;
               s3_reg  <= 1'b0;
               lvl_reg <= 1'b0;
            end else begin
               s1_reg  <= pin_i[i];
               s2_reg  <= s1_reg;
               s3_reg  <= s2_reg;
               lvl_reg <= lvl_next;
            end
         end
         assign level_o[i] = lvl_reg;
      end
   endgenerate
endmodule
`default_nettype wire

// ### inc/fac_params.svh
// flash array control: register offsets, field positions, reset values
// assumes byte-wide registers on a plain strobe port, 16-bit cpu addresses
`ifndef FAC_PARAMS_SVH
`define FAC_PARAMS_SVH
`define FAC_OFS_GUARD      8'hF4
`define FAC_OFS_MCFG       8'hF5
`define FAC_OFS_TEST       8'hF6
`define FAC_OFS_CTL        8'hF7
`define FAC_RST_GUARD      8'h00
`define FAC_RST_MCFG       8'h00
`define FAC_RST_TEST       8'h00
`define FAC_RST_CTL        8'h00
`define FAC_B_LOCK         0
`define FAC_B_BOOT_BLOCK_PROTECT        0
`define FAC_B_STRESS       7
`define FAC_B_GATE         6
`define FAC_B_HVSEEN       5
`define FAC_B_LOWV         4
`define FAC_B_OVRD         3
`define FAC_B_THRESHOLD_CHECK         2
`define FAC_B_SPARE        1
`define FAC_B_MWP          0
`define FAC_B_SWAI         7
`define FAC_B_SUPOK        6
`define FAC_B_WIPE         2
`define FAC_B_ARM          1
`define FAC_B_ENPV         0
`define FAC_BASE_SINGLE    16'h8000
`define FAC_BOOT_TOP       4'hF
`endif

// ### inc/fac_pkg.sv
// flash array control: shared types
// assumes fac_params.svh for all numeric constants
package fac_pkg;
   typedef enum logic [3:0] {
      FAC_IDLE = 4'b0001,
      FAC_RD1  = 4'b0010,
      FAC_RD2  = 4'b0100,
      FAC_DONE = 4'b1000
   } fac_rd_state_t;
endpackage

// ### verif/fac_array_model.sv
// flash array stand-in: answers a word read the cycle after the strobe
// assumes the controller's registered read strobe and word index
`timescale 1ns/1ns
`default_nettype none
module fac_array_model (
   // clock
   input  wire logic        clk_i,
   // read port
   input  wire logic        rd_i,
   input  wire logic [13:0] word_i,
   output logic      [15:0] data_o
);
   initial data_o = 16'h0000;
   always @(posedge clk_i) begin
      // outside the data cycle flip every bit, so a late sample never passes
      if (rd_i) begin
         data_o <= {2'h0, word_i} ^ 16'hA5C3;
      end else begin
         data_o <= ~data_o;
      end
   end
endmodule
`default_nettype wire

// ### verif/fac_flash_ctrl_bench.sv
// self-checking bench for the flash array controller
// assumes the array stand-in model and the bound port checker
`timescale 1ns/1ns
`default_nettype none
module fac_flash_ctrl_bench;
   logic        clk_i = 1'h0;
   logic        rst_n_i = 1'h0;
   logic        special_mode_active_i = 1'h0, expanded_mode_i = 1'h0, wait_mode_i = 1'h0;
   logic        program_supply_pin_i = 1'h0, stress_hv_pin_i = 1'h0;
   logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0, cpu_byte_i = 1'h0, cpu_rd_i = 1'h0;
   logic        cpu_wr_i = 1'h0, cpu_rvalid_o, array_rd_o, prog_byte_o, prog_dual_o;
   logic [15:0] cpu_addr_i = 16'h0000, cpu_wdata_i = 16'h0000, cpu_rdata_o;
   logic [15:0] prog_addr_o, prog_data_o;
   wire  [15:0] array_rdata_i;
   logic [13:0] array_word_o;
   logic        prog_pulse_o, erase_main_o, erase_boot_o, stress_en_o, stress_gate_o;
   logic        low_voltage_en_o, threshold_check_o, sense_timeout_dis_o, spare_row_o;
   logic        module_clk_en_o;
   int          n_mismatch = 0, n_tests = 0;
   fac_flash_ctrl fac_flash_ctrl_inst (.*);
   fac_array_model fac_array_model_inst (.clk_i(clk_i), .rd_i(array_rd_o),
      .word_i(array_word_o), .data_o(array_rdata_i));
   always #4 clk_i = ~clk_i;
   function automatic logic [15:0] w(input logic [15:0] a);
      return {2'h0, a[14:1]} ^ 16'hA5C3;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic rst;
      rst_n_i <= 1'h0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'h1;
      // let the pin synchronisers settle
      repeat (6) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'h1;
      @(posedge clk_i);
      reg_wr_i <= 1'h0;
      // idle edge: back-to-back calls never drive the strobe twice in one step
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'h1;
      @(posedge clk_i);
      reg_rd_i <= 1'h0;
      #1 check(16'(reg_rdata_o), 16'(exp));
      @(posedge clk_i);
   endtask
   task automatic cwr(input logic [15:0] a, input logic [15:0] d);
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      cpu_wr_i <= 1'h1;
      @(posedge clk_i);
      cpu_wr_i <= 1'h0;
      @(posedge clk_i);
   endtask
   // lat 8 stands for no answer at all
   task automatic crd(input logic [15:0] a, input logic b, input int lat,
                      input logic [15:0] exp, input logic [15:0] msk);
      int k;
      k = 1;
      cpu_addr_i <= a;
      cpu_byte_i <= b;
      cpu_rd_i <= 1'h1;
      @(posedge clk_i);
      cpu_rd_i <= 1'h0;
      cpu_byte_i <= 1'h0;
      #1;
      while (cpu_rvalid_o !== 1'h1 && k < 8) begin
         @(posedge clk_i);
         #1 k++;
      end
      check(16'(k), 16'(lat));
      if (lat < 8) check(cpu_rdata_o & msk, exp);
      @(posedge clk_i);
   endtask
   task automatic s_regs;
      for (int a = 8'hF3; a <= 8'hF8; a++) rd(8'(a), 8'h00);
   endtask
   task automatic s_lock;
      wr(8'hF5, 8'h01);
      rd(8'hF5, 8'h01);
      wr(8'hF4, 8'h01);
      wr(8'hF4, 8'h00);
      rd(8'hF4, 8'h01);
      wr(8'hF5, 8'h00);
      rd(8'hF5, 8'h01);
   endtask
   task automatic s_test;
      wr(8'hF6, 8'hFF);
      rd(8'hF6, 8'h00);
      special_mode_active_i <= 1'h1;
      stress_hv_pin_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      wr(8'hF6, 8'hFF);
      rd(8'hF6, 8'hFF);
      check(16'({stress_en_o, stress_gate_o, low_voltage_en_o, threshold_check_o,
         sense_timeout_dis_o, spare_row_o, prog_dual_o}), 16'h007F);
      wr(8'hF6, 8'h80);
      rd(8'hF6, 8'hA0);
      check(16'({stress_en_o, stress_gate_o}), 16'h0002);
      stress_hv_pin_i <= 1'h0;
      repeat (6) @(posedge clk_i);
      rd(8'hF6, 8'h80);
      wr(8'hF7, 8'h02);
      rd(8'hF7, 8'h00);
      wr(8'hF6, 8'h08);
      wr(8'hF7, 8'h02);
      rd(8'hF7, 8'h02);
      special_mode_active_i <= 1'h0;
      @(posedge clk_i);
      rd(8'hF6, 8'h00);
   endtask
   task automatic s_prog;
      program_supply_pin_i <= 1'h1;
      repeat (6) @(posedge clk_i);
      wr(8'hF7, 8'h01);
      rd(8'hF7, 8'h40);
      wr(8'hF7, 8'h02);
      wr(8'hF7, 8'h03);
      rd(8'hF7, 8'h42);
      cwr(16'h8010, 16'h1234);
      cwr(16'h8020, 16'h5555);
      crd(16'h8020, 1'h0, 1, 16'h1234, 16'hFFFF);
      wr(8'hF7, 8'h03);
      rd(8'hF7, 8'h43);
      check(16'({prog_pulse_o, prog_byte_o}), 16'h0002);
      check(prog_addr_o, 16'h8010);
      check(prog_data_o, 16'h1234);
      wr(8'hF7, 8'h01);
      rd(8'hF7, 8'h43);
      wr(8'hF5, 8'h01);
      rd(8'hF5, 8'h00);
      crd(16'h8010, 1'h0, 1, 16'h0000, 16'hFFFF);
      wr(8'hF7, 8'h00);
      rd(8'hF7, 8'h42);
      check(16'(prog_pulse_o), 16'h0000);
   endtask
   task automatic s_boot;
      wr(8'hF5, 8'h01);
      wr(8'hF7, 8'h02);
      cwr(16'hFA00, 16'h0F0F);
      wr(8'hF7, 8'h03);
      rd(8'hF7, 8'h43);
      check(16'(prog_pulse_o), 16'h0000);
      wr(8'hF7, 8'h02);
      wr(8'hF7, 8'h06);
      wr(8'hF7, 8'h07);
      rd(8'hF7, 8'h47);
      check(16'({erase_main_o, erase_boot_o}), 16'h0002);
      wr(8'hF7, 8'h06);
      wr(8'hF5, 8'h00);
      wr(8'hF7, 8'h07);
      rd(8'hF5, 8'h00);
      check(16'({erase_main_o, erase_boot_o}), 16'h0003);
      wr(8'hF7, 8'h00);
      program_supply_pin_i <= 1'h0;
      repeat (6) @(posedge clk_i);
      rd(8'hF7, 8'h06);
   endtask
   task automatic s_read;
      crd(16'h8004, 1'h0, 3, w(16'h8004), 16'hFFFF);
      crd(16'h8005, 1'h0, 5, (w(16'h8004) << 8) | (w(16'h8006) >> 8), 16'hFFFF);
      crd(16'h8007, 1'h1, 3, w(16'h8006) & 16'h00FF, 16'h00FF);
      crd(16'h0004, 1'h0, 8, 16'h0000, 16'h0000);
      expanded_mode_i <= 1'h1;
      @(posedge clk_i);
      crd(16'h8004, 1'h0, 8, 16'h0000, 16'h0000);
      expanded_mode_i <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic s_wait;
      wr(8'hF7, 8'h80);
      rd(8'hF7, 8'h80);
      wait_mode_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      check(16'(module_clk_en_o), 16'h0000);
      wr(8'hF7, 8'h00);
      repeat (3) @(posedge clk_i);
      check(16'(module_clk_en_o), 16'h0001);
      wait_mode_i <= 1'h0;
   endtask
   initial begin
      rst();
      s_regs();
      s_lock();
      rst();
      s_test();
      rst();
      s_prog();
      rst();
      s_boot();
      s_read();
      s_wait();
      wrap_up();
   end
endmodule
`default_nettype wire

// ### verif/fac_flash_ctrl_checker.sv
// port checker for the flash array controller
// assumes one clock domain; bound to every controller instance
`timescale 1ns/1ns
`default_nettype none
module fac_flash_ctrl_checker (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // inputs
   input wire logic        special_mode_active_i,
   input wire logic        expanded_mode_i,
   input wire logic        wait_mode_i,
   input wire logic        reg_rd_i,
   input wire logic        cpu_rd_i,
   input wire logic        cpu_byte_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic [15:0] array_rdata_i,
   // outputs
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        cpu_rvalid_o,
   input wire logic [15:0] cpu_rdata_o,
   input wire logic        array_rd_o,
   input wire logic [13:0] array_word_o,
   input wire logic [15:0] prog_addr_o,
   input wire logic [15:0] prog_data_o,
   input wire logic        prog_pulse_o,
   input wire logic        erase_main_o,
   input wire logic        erase_boot_o,
   input wire logic        stress_en_o,
   input wire logic        low_voltage_en_o,
   input wire logic        threshold_check_o,
   input wire logic        sense_timeout_dis_o,
   input wire logic        spare_row_o,
   input wire logic        module_clk_en_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("register read data outside its cycle");
   a_low_half: assert property (cpu_rd_i && !cpu_addr_i[15] |=> !array_rd_o)
      else $error("lower half read reached the array");
   a_off_map: assert property (expanded_mode_i && $past(expanded_mode_i) |-> !array_rd_o)
      else $error("array read while off the map");
   a_word_read: assert property (
      array_rd_o && $past(cpu_rd_i && !cpu_byte_i && !cpu_addr_i[0]) |->
      array_word_o == $past(cpu_addr_i[14:1]) ##2 cpu_rvalid_o && cpu_rdata_o == $past(array_rdata_i))
      else $error("aligned word read not answered in three cycles");
   a_clk_run: assert property (!wait_mode_i [*2] |-> module_clk_en_o)
      else $error("module clock halted outside wait");
   a_test_gated: assert property (!special_mode_active_i [*2] |->
      !(stress_en_o || low_voltage_en_o || threshold_check_o || spare_row_o))
      else $error("test control active in normal mode");
   a_timeout_pair: assert property (threshold_check_o == sense_timeout_dis_o)
      else $error("threshold check and timeout disable differ");
   a_prog_erase: assert property (!(prog_pulse_o && erase_main_o))
      else $error("program and erase at once");
   a_boot_erase: assert property (erase_boot_o |-> erase_main_o)
      else $error("boot erase without array erase");
   a_latch_hold: assert property (prog_pulse_o |-> $stable(prog_addr_o) && $stable(prog_data_o))
      else $error("latched address or data moved while programming");
   c_read: cover property (cpu_rvalid_o);
   c_prog: cover property (prog_pulse_o);
   c_erase: cover property (erase_main_o && erase_boot_o);
   c_halt: cover property (!module_clk_en_o);
endmodule
bind fac_flash_ctrl fac_flash_ctrl_checker fac_flash_ctrl_checker_inst (.*);
`default_nettype wire
